// >>> pci_csr_defs.vh
`ifndef PCI_CSR_DEFS_VH
`define PCI_CSR_DEFS_VH

// Register indices; each 64-bit register is two words, low word at 2*index.
`define IDX_ERR_STATUS      4'h0
`define IDX_ERR_CAPTURE     4'h1
`define IDX_SPECIAL_CYCLE   4'h2
`define IDX_SPARSE_UPPER    4'h3
`define IDX_IO_UPPER        4'h4
`define IDX_CONFIG_TYPE     4'h5
`define IDX_DENSE_UPPER     4'h6
`define IDX_HOLE_BOUNDS     4'h7
`define IDX_WIN_A_BOUNDS    4'h8
`define IDX_WIN_A_SIZE      4'h9
`define IDX_WIN_A_XLATE     4'ha
`define IDX_WIN_B_BOUNDS    4'hb
`define IDX_WIN_B_SIZE      4'hc
`define IDX_WIN_B_XLATE     4'hd
`define IDX_ERR_CONTROL     4'he

// Error status bit positions.
`define ST_TIMEOUT_BIT      5
`define ST_NMI_BIT          6
`define ST_WIDTH            7

// Error control register fields.
`define CTL_PCI_RESET_BIT   8
`define CTL_EN_RST          7'h00

// Hole register fields.
`define HOLE_END_LSB        0
`define HOLE_FIXED_EN_BIT   13
`define HOLE_PROG_EN_BIT    14
`define HOLE_START_LSB      15

// Window bounds, size and translated base register fields.
`define WIN_END_LSB         0
`define WIN_SG_BIT          18
`define WIN_EN_BIT          19
`define WIN_START_LSB       20
`define WIN_MASK_LSB        20
`define XLATE_BASE_LSB      9

// Fixed hole, 512KB up to but not including 1MB.
`define FIXED_HOLE_LO       32'h0008_0000
`define FIXED_HOLE_HI       32'h0010_0000

// Capture register command field width in the high word.
`define CAP_CMD_WIDTH       5

`endif

// >>> pci_err_window_csrs.v
// Summary of operation
// - Device timeout while PCI master sets its flag; flag raises hardware error line.
// - NMI input sets status bit 6; bit raises hardware error line.
// - Status bits clear by writing one, by reset, or by PCI reset bit.
// - Capture register holds failing address 31:0 and command 36:32.
// - Capture loads every PCI cycle start, no reset, software writes ignored.
// - Parity error freezes capture until its status bit is cleared.
// - Special cycle register high word write issues one special cycle; reads return zero.
// - Sparse memory accesses use upper address register bits 4:0 as AD 31:27.
// - I/O accesses use upper address register bits 8:0 as AD 31:23.
// - Config accesses use register bits 31:30 as AD 1:0 (cycle type).
// - Dense memory accesses use register bits 1:0 as AD 31:30.
// - Fixed hole enable bit 13 blocks claims from 512KB to 1MB.
// - Programmable hole bit 14 blocks AD 23:15 between start and end.
// - Window enable bit 19 claims AD 31:20 within start and end fields.
// - Window bit 18 selects scatter-gather, else direct mapping.
// - Window mask bits 30:20 shape direct-mapped translation; start and end fields size the window.
// - Translated base 30:9 is table base or direct system base.
// - A second identical target window exists.
// - Reserved bits of status and capture read zero, are read-only.
`timescale 1ns/10ps
`include "pci_csr_defs.vh"

module pci_err_window_csrs (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Avalon-MM register slave (word addressed)
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Error event sources from the PCI interface, and the hardware error line
    input  wire [3:0]  parity_err_pulse,
    input  wire        dev_timeout_pulse,
    input  wire        nmi_in,
    input  wire        pci_cycle_start,
    input  wire [31:0] pci_cycle_addr,
    input  wire [4:0]  pci_cycle_cmd,
    output reg         hw_error_int,
    // Special cycle request towards the PCI interface
    output reg         special_cycle_req,
    output reg  [63:0] special_cycle_data,
    // Outbound upper address bits
    output reg  [4:0]  sparse_mem_upper_addr,
    output reg  [8:0]  io_space_upper_addr,
    output reg  [1:0]  config_cycle_type_addr,
    output reg  [1:0]  dense_mem_upper_addr,
    // Inbound address decode
    input  wire        in_valid,
    input  wire [31:0] in_addr,
    output reg         in_claim,
    output reg         in_window_b,
    output reg         in_scatter_gather,
    output reg  [31:0] in_sys_addr
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [`ST_WIDTH-1:0] status_r;
    reg [`ST_WIDTH-1:0] err_en_r;
    reg                 pci_reset_r;
    reg [31:0]          cap_addr_r;
    reg [4:0]           cap_cmd_r;
    reg [31:0]          scm_low_r;
    reg [8:0]           hole_end_r;
    reg [8:0]           hole_start_r;
    reg                 hole_fixed_en_r;
    reg                 hole_prog_en_r;
    reg [11:0]          win_end_r   [0:1];
    reg [11:0]          win_start_r [0:1];
    reg                 win_en_r    [0:1];
    reg                 win_sg_r    [0:1];
    reg [10:0]          win_mask_r  [0:1];
    reg [21:0]          win_tba_r   [0:1];

    reg [31:0]          rd_word;
    reg [`ST_WIDTH-1:0] status_nxt;

    wire       acc_done  = ~avs_waitrequest;
    wire       wr_now    = avs_write & acc_done;
    wire       rd_take   = avs_read & avs_waitrequest;
    wire [3:0] wr_idx    = avs_address[4:1];
    wire       wr_high   = avs_address[0];
    wire       frozen    = |status_r[3:0];
    // Window B registers sit at indices above those of window A.
    wire       rd_b      = (wr_idx > 4'ha);

    // Merges write data into an old word under the byte enables.
    function [31:0] be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer      k;
        begin
            be_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    be_merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // True when a write to the low word of register idx is being committed.
    function wr_low_hit;
        input [3:0] idx;
        begin
            wr_low_hit = wr_now & ~wr_high & (wr_idx == idx);
        end
    endfunction

    // Window hit on AD 31:20, inclusive at both ends.
    function win_hit;
        input        en;
        input [11:0] start;
        input [11:0] stop;
        input [11:0] a;
        begin
            win_hit = en & (a >= start) & (a <= stop);
        end
    endfunction

    // Direct-mapped translation: masked bits come from the translated base.
    function [31:0] direct_xlate;
        input [31:0] a;
        input [10:0] mask;
        input [21:0] tba;
        reg   [31:0] m;
        reg   [31:0] base;
        begin
            m            = {1'b0, mask, 20'h00000};
            base         = {1'b0, tba, 9'h000};
            direct_xlate = (a & ~m) | (base & m);
        end
    endfunction

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Waitrequest drops for one cycle after a request is seen, so every
    // access takes exactly two cycles and never commits twice.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (rd_take) begin
                avs_readdata <= rd_word;
            end
        end
    end

    // Read decode; reserved and unmapped locations read as zero.
    always @* begin
        rd_word = 32'h00000000;
        case ({avs_address[4:1], avs_address[0]})
            {`IDX_ERR_STATUS, 1'b0}: begin
                rd_word[`ST_WIDTH-1:0] = status_r;
            end
            {`IDX_ERR_CAPTURE, 1'b0}: begin
                rd_word = cap_addr_r;
            end
            {`IDX_ERR_CAPTURE, 1'b1}: begin
                rd_word[`CAP_CMD_WIDTH-1:0] = cap_cmd_r;
            end
            {`IDX_SPARSE_UPPER, 1'b0}: begin
                rd_word[4:0] = sparse_mem_upper_addr;
            end
            {`IDX_IO_UPPER, 1'b0}: begin
                rd_word[8:0] = io_space_upper_addr;
            end
            {`IDX_CONFIG_TYPE, 1'b0}: begin
                rd_word[31:30] = config_cycle_type_addr;
            end
            {`IDX_DENSE_UPPER, 1'b0}: begin
                rd_word[1:0] = dense_mem_upper_addr;
            end
            {`IDX_HOLE_BOUNDS, 1'b0}: begin
                rd_word[`HOLE_END_LSB +: 9]    = hole_end_r;
                rd_word[`HOLE_FIXED_EN_BIT]    = hole_fixed_en_r;
                rd_word[`HOLE_PROG_EN_BIT]     = hole_prog_en_r;
                rd_word[`HOLE_START_LSB +: 9]  = hole_start_r;
            end
            {`IDX_WIN_A_BOUNDS, 1'b0}, {`IDX_WIN_B_BOUNDS, 1'b0}: begin
                rd_word[`WIN_END_LSB +: 12]   = win_end_r[rd_b];
                rd_word[`WIN_SG_BIT]          = win_sg_r[rd_b];
                rd_word[`WIN_EN_BIT]          = win_en_r[rd_b];
                rd_word[`WIN_START_LSB +: 12] = win_start_r[rd_b];
            end
            {`IDX_WIN_A_SIZE, 1'b0}, {`IDX_WIN_B_SIZE, 1'b0}: begin
                rd_word[`WIN_MASK_LSB +: 11] = win_mask_r[rd_b];
            end
            {`IDX_WIN_A_XLATE, 1'b0}, {`IDX_WIN_B_XLATE, 1'b0}: begin
                rd_word[`XLATE_BASE_LSB +: 22] = win_tba_r[rd_b];
            end
            {`IDX_ERR_CONTROL, 1'b0}: begin
                rd_word[`ST_WIDTH-1:0]      = err_en_r;
                rd_word[`CTL_PCI_RESET_BIT] = pci_reset_r;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Error status and hardware error line
    // ----------------------------------------------------------------
    // A new event wins over a write-one-to-clear in the same cycle, so no
    // event is lost; the PCI reset bit clears unconditionally.
    always @* begin
        status_nxt = status_r;
        if (wr_low_hit(`IDX_ERR_STATUS)) begin
            status_nxt = status_r & ~avs_writedata[`ST_WIDTH-1:0];
        end
        status_nxt = status_nxt
                   | ({3'b000, parity_err_pulse} & err_en_r);
        if (dev_timeout_pulse & err_en_r[`ST_TIMEOUT_BIT]) begin
            status_nxt[`ST_TIMEOUT_BIT] = 1'b1;
        end
        if (nmi_in & err_en_r[`ST_NMI_BIT]) begin
            status_nxt[`ST_NMI_BIT] = 1'b1;
        end
        if (pci_reset_r) begin
            status_nxt = {`ST_WIDTH{1'b0}};
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_r     <= {`ST_WIDTH{1'b0}};
            hw_error_int <= 1'b0;
        end else begin
            status_r     <= status_nxt;
            hw_error_int <= |status_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Error capture
    // ----------------------------------------------------------------
    // No reset on purpose: after a crash the failing cycle must survive
    // any reset so software can still read it.
    always @(posedge clk_sys) begin
        if (pci_cycle_start & ~frozen) begin
            cap_addr_r <= pci_cycle_addr;
            cap_cmd_r  <= pci_cycle_cmd;
        end
    end

    // ----------------------------------------------------------------
    // Special cycle
    // ----------------------------------------------------------------
    // The low word is staged; writing the high word launches one cycle
    // with the full 64-bit message.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scm_low_r          <= 32'h00000000;
            special_cycle_req  <= 1'b0;
            special_cycle_data <= 64'h0000000000000000;
        end else begin
            special_cycle_req <= 1'b0;
            if (wr_low_hit(`IDX_SPECIAL_CYCLE)) begin
                scm_low_r <= avs_writedata;
            end
            if (wr_now & wr_high & (wr_idx == `IDX_SPECIAL_CYCLE)) begin
                special_cycle_req  <= 1'b1;
                special_cycle_data <= {avs_writedata, scm_low_r};
            end
        end
    end

    // ----------------------------------------------------------------
    // Read/write configuration registers
    // ----------------------------------------------------------------
    // Only the documented field bits are stored; reserved bits read zero.
    wire [31:0] io_merged = be_merge({23'h0, io_space_upper_addr}, avs_writedata, avs_byteenable);
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sparse_mem_upper_addr  <= 5'h00;
            io_space_upper_addr    <= 9'h000;
            config_cycle_type_addr <= 2'h0;
            dense_mem_upper_addr   <= 2'h0;
            hole_end_r             <= 9'h000;
            hole_start_r           <= 9'h000;
            hole_fixed_en_r        <= 1'b0;
            hole_prog_en_r         <= 1'b0;
            err_en_r               <= `CTL_EN_RST;
            pci_reset_r            <= 1'b0;
        end else begin
            if (wr_low_hit(`IDX_SPARSE_UPPER) & avs_byteenable[0]) begin
                sparse_mem_upper_addr <= avs_writedata[4:0];
            end
            if (wr_low_hit(`IDX_IO_UPPER)) begin
                io_space_upper_addr <= io_merged[8:0];
            end
            if (wr_low_hit(`IDX_CONFIG_TYPE) & avs_byteenable[3]) begin
                config_cycle_type_addr <= avs_writedata[31:30];
            end
            if (wr_low_hit(`IDX_DENSE_UPPER) & avs_byteenable[0]) begin
                dense_mem_upper_addr <= avs_writedata[1:0];
            end
            if (wr_low_hit(`IDX_HOLE_BOUNDS)) begin
                hole_end_r      <= avs_writedata[`HOLE_END_LSB +: 9];
                hole_fixed_en_r <= avs_writedata[`HOLE_FIXED_EN_BIT];
                hole_prog_en_r  <= avs_writedata[`HOLE_PROG_EN_BIT];
                hole_start_r    <= avs_writedata[`HOLE_START_LSB +: 9];
            end
            if (wr_low_hit(`IDX_ERR_CONTROL)) begin
                err_en_r    <= avs_writedata[`ST_WIDTH-1:0];
                pci_reset_r <= avs_writedata[`CTL_PCI_RESET_BIT];
            end
        end
    end

    // Two identical target windows, one generate pass each.
    genvar w;
    generate
        for (w = 0; w < 2; w = w + 1) begin : g_win
            wire [3:0] base_idx = (w == 0) ? `IDX_WIN_A_BOUNDS : `IDX_WIN_B_BOUNDS;
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    win_end_r[w]   <= 12'h000;
                    win_start_r[w] <= 12'h000;
                    win_en_r[w]    <= 1'b0;
                    win_sg_r[w]    <= 1'b0;
                    win_mask_r[w]  <= 11'h000;
                    win_tba_r[w]   <= 22'h000000;
                end else begin
                    if (wr_low_hit(base_idx)) begin
                        win_end_r[w]   <= avs_writedata[`WIN_END_LSB +: 12];
                        win_sg_r[w]    <= avs_writedata[`WIN_SG_BIT];
                        win_en_r[w]    <= avs_writedata[`WIN_EN_BIT];
                        win_start_r[w] <= avs_writedata[`WIN_START_LSB +: 12];
                    end
                    if (wr_low_hit(base_idx + 4'h1)) begin
                        win_mask_r[w] <= avs_writedata[`WIN_MASK_LSB +: 11];
                    end
                    if (wr_low_hit(base_idx + 4'h2)) begin
                        win_tba_r[w] <= avs_writedata[`XLATE_BASE_LSB +: 22];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Inbound decode
    // ----------------------------------------------------------------
    // Holes override windows; window A wins where both windows overlap.
    wire hit_a     = win_hit(win_en_r[0], win_start_r[0], win_end_r[0], in_addr[31:20]);
    wire hit_b     = win_hit(win_en_r[1], win_start_r[1], win_end_r[1], in_addr[31:20]);
    wire fixed_h   = hole_fixed_en_r & (in_addr >= `FIXED_HOLE_LO)
                   & (in_addr < `FIXED_HOLE_HI);
    wire prog_h    = hole_prog_en_r & (in_addr[23:15] >= hole_start_r)
                   & (in_addr[23:15] <= hole_end_r);
    wire use_b     = ~hit_a & hit_b;
    wire sel_sg    = use_b ? win_sg_r[1] : win_sg_r[0];
    wire [10:0] sel_mask = use_b ? win_mask_r[1] : win_mask_r[0];
    wire [21:0] sel_tba  = use_b ? win_tba_r[1] : win_tba_r[0];

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            in_claim          <= 1'b0;
            in_window_b       <= 1'b0;
            in_scatter_gather <= 1'b0;
            in_sys_addr       <= 32'h00000000;
        end else begin
            in_claim          <= in_valid & (hit_a | hit_b) & ~fixed_h & ~prog_h;
            in_window_b       <= use_b;
            in_scatter_gather <= sel_sg;
            if (sel_sg) begin
                in_sys_addr <= {1'b0, sel_tba, 9'h000};
            end else begin
                in_sys_addr <= direct_xlate(in_addr, sel_mask, sel_tba);
            end
        end
    end

endmodule

// >>> pci_err_window_csrs_chk.sv
`timescale 1ns/10ps
// ----------------------------------------------
// Port checker for the error and window CSRs
// ----------------------------------------------
module pci_err_window_csrs_chk (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // Register bus
    input wire [4:0]  avs_address,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire        avs_waitrequest,
    // Events, interrupt and special cycle
    input wire [3:0]  parity_err_pulse,
    input wire        dev_timeout_pulse,
    input wire        nmi_in,
    input wire        hw_error_int,
    input wire        special_cycle_req,
    input wire [63:0] special_cycle_data,
    // Upper address outputs and decode
    input wire [4:0]  sparse_mem_upper_addr,
    input wire [8:0]  io_space_upper_addr,
    input wire [1:0]  config_cycle_type_addr,
    input wire [1:0]  dense_mem_upper_addr,
    input wire        in_valid,
    input wire        in_claim
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // A write counts only at the edge where waitrequest is low.
    wire       commit = avs_write && !avs_waitrequest && (avs_byteenable == 4'hf);
    reg [31:0] wd_q;
    reg        ev_q;
    reg        hi_q;
    // Last cycle's causes.
    always @(posedge clk_sys) begin
        wd_q <= avs_writedata;
        ev_q <= dev_timeout_pulse || nmi_in || (|parity_err_pulse);
        hi_q <= commit && (avs_address == 5'd5);
    end
    sequence s_hi_commit;
        commit && (avs_address == 5'd5);
    endsequence
    sequence s_one_pulse;
        special_cycle_req ##1 !special_cycle_req;
    endsequence
    a_spc_launch: assert property (s_hi_commit |=> s_one_pulse)
        else $error("special cycle not launched once");
    a_spc_cause: assert property (special_cycle_req |-> hi_q)
        else $error("special cycle without high word write");
    a_spc_data: assert property (s_hi_commit |=> special_cycle_data[63:32] == wd_q)
        else $error("special cycle data wrong");
    a_sparse_load: assert property (commit && avs_address == 5'd6
        |=> sparse_mem_upper_addr == wd_q[4:0])
        else $error("sparse upper bits wrong");
    a_io_load: assert property (commit && avs_address == 5'd8
        |=> io_space_upper_addr == wd_q[8:0])
        else $error("io upper bits wrong");
    a_cfg_load: assert property (commit && avs_address == 5'd10
        |=> config_cycle_type_addr == wd_q[31:30])
        else $error("config type bits wrong");
    a_dense_load: assert property (commit && avs_address == 5'd12
        |=> dense_mem_upper_addr == wd_q[1:0])
        else $error("dense upper bits wrong");
    a_claim_cause: assert property (in_claim |-> $past(in_valid))
        else $error("claim without inbound cycle");
    a_hwint_rise: assert property ($rose(hw_error_int) |-> ev_q)
        else $error("error interrupt without event");
    a_hwint_fall: assert property ($fell(hw_error_int) |-> $past(commit) || $past(commit, 2))
        else $error("error interrupt dropped without write");
endmodule

bind pci_err_window_csrs pci_err_window_csrs_chk i_pci_err_window_csrs_chk (.*);

// >>> pci_agent_model.sv
`timescale 1ns/10ps
module pci_agent_model (
    // Clock
    input  wire        clk_sys,
    // Events and cycles towards the bridge
    output reg  [3:0]  parity_err_pulse = 4'h0,
    output reg         dev_timeout_pulse = 1'b0,
    output reg         nmi_in = 1'b0,
    output reg         pci_cycle_start = 1'b0,
    output reg  [31:0] pci_cycle_addr = 32'h0,
    output reg  [4:0]  pci_cycle_cmd = 5'h0,
    output reg         in_valid = 1'b0,
    output reg  [31:0] in_addr = 32'h0,
    // Special cycle from the bridge
    input  wire        special_cycle_req
);
    integer spc_cnt = 0;
    always @(posedge clk_sys) begin
        if (special_cycle_req === 1'b1) spc_cnt = spc_cnt + 1;
    end
    // One-cycle event; k below 4 is a parity bit, 4 is a device timeout.
    task pulse(input integer k);
        begin
            @(posedge clk_sys);
            if (k < 4) parity_err_pulse[k] <= 1'b1;
            else dev_timeout_pulse <= 1'b1;
            @(posedge clk_sys);
            parity_err_pulse <= 4'h0;
            dev_timeout_pulse <= 1'b0;
        end
    endtask
    task nmi(input v);
        begin
            @(posedge clk_sys);
            nmi_in <= v;
        end
    endtask
    // A released bus shows inverted stale values.
    task cycle(input [31:0] a, input [4:0] c);
        begin
            @(posedge clk_sys);
            pci_cycle_start <= 1'b1;
            pci_cycle_addr <= a;
            pci_cycle_cmd <= c;
            @(posedge clk_sys);
            pci_cycle_start <= 1'b0;
            pci_cycle_addr <= ~a;
            pci_cycle_cmd <= ~c;
        end
    endtask
    // Returns at the edge where the result is sampled.
    task decode(input [31:0] a);
        begin
            @(posedge clk_sys);
            in_valid <= 1'b1;
            in_addr <= a;
            @(posedge clk_sys);
            in_valid <= 1'b0;
            in_addr <= ~a;
            @(posedge clk_sys);
        end
    endtask
endmodule

// >>> pci_err_window_csrs_bench.sv
`timescale 1ns/10ps
module pci_err_window_csrs_bench;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [4:0]  avs_address = 5'h00;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [3:0]  avs_byteenable = 4'hf;
    wire [31:0] avs_readdata, in_sys_addr, pci_cycle_addr, in_addr;
    wire [63:0] special_cycle_data;
    wire [3:0]  parity_err_pulse;
    wire [4:0]  pci_cycle_cmd, sparse_mem_upper_addr;
    wire [8:0]  io_space_upper_addr;
    wire [1:0]  config_cycle_type_addr, dense_mem_upper_addr;
    wire        avs_waitrequest, dev_timeout_pulse, nmi_in, pci_cycle_start, hw_error_int;
    wire        special_cycle_req, in_valid, in_claim, in_window_b, in_scatter_gather;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         spc_base;
    logic [4:0]  ua [4] = '{5'd6, 5'd8, 5'd10, 5'd12};
    logic [31:0] um [4] = '{32'h1f, 32'h1ff, 32'hc000_0000, 32'h3};

    pci_err_window_csrs i_pci_err_window_csrs (.*);
    pci_agent_model i_pci_agent_model (.*);

    always #50 clk_sys = ~clk_sys;

    // ------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------
    // The request is held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) error_cnt++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk("readdata", e, q);
    endtask
    task automatic dec(input logic [31:0] a, input logic [2:0] e, input logic [31:0] s);
        i_pci_agent_model.decode(a);
        chk("claim_b_sg", e, {in_claim, in_window_b, in_scatter_gather});
        if (e[2]) chk("sys_addr", s, in_sys_addr);
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog, far beyond what the tests need.
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        complete_run;
    end

    // ------------------------------------------
    // Test sequence
    // ------------------------------------------
    initial begin
        logic [31:0] q;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(5'd0, 32'h0);
        rd(5'd4, 32'h0);
        rd(5'd30, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(ua[i], 32'hffff_ffff);
            rd(ua[i], um[i]);
        end
        bus(1'b1, 5'd6, 32'h0, 4'h0, q);
        chk("upper", {5'h1f, 9'h1ff, 2'h3, 2'h3}, {sparse_mem_upper_addr,
            io_space_upper_addr, config_cycle_type_addr, dense_mem_upper_addr});
        $display("test upper done");
        wr(5'd28, 32'h7f);
        i_pci_agent_model.pulse(4);
        rd(5'd0, 32'h20);
        chk("hw_error_int", 1, hw_error_int);
        i_pci_agent_model.nmi(1'b1);
        rd(5'd0, 32'h60);
        i_pci_agent_model.nmi(1'b0);
        wr(5'd0, 32'h20);
        rd(5'd0, 32'h40);
        wr(5'd0, 32'hffff_ffff);
        rd(5'd1, 32'h0);
        rd(5'd0, 32'h0);
        chk("hw_error_int", 0, hw_error_int);
        i_pci_agent_model.pulse(4);
        wr(5'd28, 32'h17f);
        rd(5'd0, 32'h0);
        wr(5'd28, 32'h0);
        i_pci_agent_model.pulse(4);
        rd(5'd0, 32'h0);
        chk("hw_error_int", 0, hw_error_int);
        $display("test status done");
        wr(5'd28, 32'h7f);
        i_pci_agent_model.cycle(32'h1234_5678, 5'h0b);
        rd(5'd2, 32'h1234_5678);
        rd(5'd3, 32'h0000_000b);
        i_pci_agent_model.pulse(0);
        i_pci_agent_model.cycle(32'h9abc_def0, 5'h07);
        wr(5'd2, 32'h0);
        rd(5'd2, 32'h1234_5678);
        wr(5'd0, 32'h1);
        i_pci_agent_model.cycle(32'h0bad_f00d, 5'h1f);
        rd(5'd2, 32'h0bad_f00d);
        rd(5'd3, 32'h1f);
        i_pci_agent_model.pulse(4);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(5'd0, 32'h0);
        rd(5'd2, 32'h0bad_f00d);
        $display("test capture done");
        spc_base = i_pci_agent_model.spc_cnt;
        wr(5'd4, 32'h5566_7788);
        wr(5'd5, 32'h1122_3344);
        repeat (3) @(posedge clk_sys);
        chk("spc_cnt", spc_base + 1, i_pci_agent_model.spc_cnt);
        chk("spc_data", 64'h1122_3344_5566_7788, special_cycle_data);
        rd(5'd5, 32'h0);
        $display("test special done");
        wr(5'd14, 32'h0000_2000);
        wr(5'd16, 32'h0008_010f);
        wr(5'd18, 32'h00f0_0000);
        wr(5'd20, 32'h2340_0000);
        wr(5'd22, 32'h200c_0200);
        wr(5'd26, 32'h0001_2200);
        dec(32'h1054_3210, 3'b100, 32'h1044_3210);
        dec(32'h10ff_ffff, 3'b100, 32'h104f_ffff);
        dec(32'h1100_0000, 3'b000, 32'h0);
        dec(32'h2001_0000, 3'b111, 32'h0001_2200);
        dec(32'h0008_0000, 3'b000, 32'h0);
        dec(32'h0007_fffc, 3'b100, 32'h0047_fffc);
        wr(5'd14, 32'h0010_4021);
        dec(32'h0010_8000, 3'b000, 32'h0);
        dec(32'h0011_0000, 3'b100, 32'h0041_0000);
        wr(5'd16, 32'h0000_010f);
        dec(32'h1054_3210, 3'b000, 32'h0);
        $display("test decode done");
        complete_run;
    end
endmodule
